/* File: hw/pwm_pkg.sv */
// Constants shared by the four-channel modulated waveform timer
//
// Summary of operation
// R1 - Four 8-bit channels drive port lines 0-3
// R2 - Each channel: own counter, period, duty
// R3 - Period match ends cycle, duty match flips
// R4 - Period/duty buffered until rollover or disable
// R5 - Write period/duty then counter applies at once
// R6 - Bit 7 chains 3-4, bit 6 chains 1-2
// R7 - Chained pair clocked from low-order channel source
// R8 - High byte is channel 1/3; output on 2/4
// R9 - Chained pair releases lines of channels 1, 3
// R10 - High byte read latches low byte one cycle
// R11 - Low counter write clears pair; high ignored
// R12 - Clock A is bus clock over 1,2,4,8
// R13 - Clock B is bus clock over 2^code
// R14 - Scaler counter matches scale, resets, toggles stage
// R15 - Scaled clock spans clock A/2 to A/512
// R16 - Channel clock: scaled or fixed pair prescaler
// R17 - Clock select bit 3 always reads zero
// R18 - Polarity set starts high, low at duty
// R19 - Scale zero divides clock A by 512
// R20 - Enable forces output, clock joins at edge
// R21 - Counter write clears it and reloads period
// R22 - All counting uses enables of one clock
// R23 - Zero reset except period/duty (FF) and pin_oe_n (F); disabled holds count
package pwm_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_CLK_SEL = 8'h60;
	localparam logic [7:0] OFF_POL_SRC = 8'h61;
	localparam logic [7:0] OFF_SCALE   = 8'h62;
	localparam logic [7:0] OFF_ENABLE  = 8'h63;
	localparam logic [7:0] OFF_CNT     = 8'h64;
	localparam logic [7:0] OFF_PER     = 8'h68;
	localparam logic [7:0] OFF_DTY     = 8'h6C;

	// ==========================================================
	// Field positions and masks
	localparam int         NUM_CH       = 4;
	localparam int         CHAIN12_BIT  = 6;
	localparam int         CHAIN34_BIT  = 7;
	localparam int         CLK_A_LSB    = 4;
	localparam int         CLK_B_LSB    = 0;
	localparam int         POL_LSB      = 0;
	localparam int         SRC_LSB      = 4;
	localparam int         EN_LSB       = 0;
	localparam logic [7:0] CLK_SEL_MASK = 8'hF7;
	localparam logic [7:0] ENABLE_MASK  = 8'hCF;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_PER  = 8'hFF;
	localparam logic [7:0] RST_DTY  = 8'hFF;

	// ==========================================================
	// Timing
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         DIV_W         = 7;

endpackage

/* File: hw/pwm_timer.sv */
// Four-channel modulated waveform timer with prescalers and pair chaining
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
module pwm_timer
	import pwm_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic      [3:0] wave_out,
	output logic      [3:0] pin_oe_n
);

	// ==========================================================
	// Storage
	logic [7:0]       clk_sel;
	logic [7:0]       pol_src;
	logic [7:0]       scale;
	logic [7:0]       enable;
	logic [7:0]       per       [NUM_CH];
	logic [7:0]       dty       [NUM_CH];
	logic [7:0]       cnt       [NUM_CH];
	logic [7:0]       pbuf      [NUM_CH];
	logic [7:0]       dbuf      [NUM_CH];
	logic [7:0]       next_cnt  [NUM_CH];
	logic [7:0]       next_pbuf [NUM_CH];
	logic [7:0]       next_dbuf [NUM_CH];
	logic [3:0]       wave;
	logic [3:0]       next_wave;
	logic [3:0]       run;
	logic [3:0]       tick;
	logic [3:0]       cnt_wr;
	logic [1:0]       chain;
	logic [DIV_W-1:0] e_div;
	logic             a_en;
	logic             b_en;
	logic             s_en;
	logic             s_match;
	logic [7:0]       scnt;
	logic             s_ff;
	logic             lat_vld;
	logic [7:0]       lat_addr;
	logic [7:0]       lat_val;
	logic [7:0]       next_rdata;
	logic             hi_read;

	assign chain = {clk_sel[CHAIN34_BIT], clk_sel[CHAIN12_BIT]}; // R6

	// ==========================================================
	// Prescalers
	// A divide by 2^k is the cycle where the low k bits are all ones
	function automatic logic div_tick(input logic [DIV_W-1:0] ctr, input logic [2:0] k);
		logic [DIV_W-1:0] m;
		m = DIV_W'((8'h01 << k) - 8'h01);
		return (ctr & m) == m;
	endfunction

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			e_div <= '0;
		end else begin
			e_div <= e_div + DIV_W'(1); // R22
		end
	end

	assign a_en = div_tick(e_div, {1'b0, clk_sel[CLK_A_LSB+1:CLK_A_LSB]}); // R12
	assign b_en = div_tick(e_div, clk_sel[CLK_B_LSB+2:CLK_B_LSB]); // R13

	// Scale minus one wraps to FF when scale is zero
	assign s_match = scnt == 8'(scale - 8'h01); // R19
	// Output stage fires once per two matches
	assign s_en = a_en & s_match & s_ff; // R15

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scnt <= '0;
			s_ff <= 1'b0;
		end else if (a_en) begin
			if (s_match) begin
				scnt <= '0; // R14
				s_ff <= ~s_ff; // R14
			end else begin
				scnt <= scnt + 8'h01;
			end
		end
	end

	// ==========================================================
	// Channel clock selection and synchronised enable
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			// Pair 1-2 uses clock A, pair 3-4 clock B unless scaled
			if (pol_src[SRC_LSB+i]) begin
				tick[i] = s_en; // R16
			end else begin
				tick[i] = (i < 2) ? a_en : b_en; // R16
			end
		end
	end

	// Run only changes on the channel's own tick so no partial period
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			run <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (tick[i]) begin
					run[i] <= enable[EN_LSB+i]; // R20
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			cnt_wr[i] = wr && (addr == OFF_CNT + 8'(i));
		end
	end

	// ==========================================================
	// Channel counters, buffers and waveform
	always_comb begin
		logic        step;
		logic        at_end;
		logic        ld;
		logic [15:0] c16;
		logic [15:0] n16;
		logic        pol;
		int          hi;
		int          lo;
		step   = 1'b0;
		at_end = 1'b0;
		ld     = 1'b0;
		c16    = '0;
		n16    = '0;
		pol    = 1'b0;
		hi     = 0;
		lo     = 0;
		for (int i = 0; i < NUM_CH; i++) begin
			pol    = pol_src[POL_LSB+i];
			step   = run[i] && tick[i];
			at_end = cnt[i] == pbuf[i]; // R3
			ld     = !run[i] || (step && at_end) || cnt_wr[i]; // R4
			next_pbuf[i] = ld ? per[i] : pbuf[i]; // R5
			next_dbuf[i] = ld ? dty[i] : dbuf[i]; // R5
			if (cnt_wr[i] || (step && at_end)) begin
				next_cnt[i] = '0; // R21
			end else if (step) begin
				next_cnt[i] = cnt[i] + 8'h01; // R2
			end else begin
				next_cnt[i] = cnt[i]; // R23
			end
			next_wave[i] = (!run[i] || (step && at_end)) ? pol : wave[i]; // R18
			if (step && next_cnt[i] == next_dbuf[i]) begin
				next_wave[i] = ~pol; // R3
			end
		end
		for (int p = 0; p < 2; p++) begin
			if (chain[p]) begin
				hi     = 2 * p;
				lo     = 2 * p + 1;
				pol    = pol_src[POL_LSB+lo];
				c16    = {cnt[hi], cnt[lo]}; // R8
				step   = run[lo] && tick[lo]; // R7
				at_end = c16 == {pbuf[hi], pbuf[lo]};
				ld     = !run[lo] || (step && at_end) || cnt_wr[lo];
				next_pbuf[hi] = ld ? per[hi] : pbuf[hi];
				next_pbuf[lo] = ld ? per[lo] : pbuf[lo];
				next_dbuf[hi] = ld ? dty[hi] : dbuf[hi];
				next_dbuf[lo] = ld ? dty[lo] : dbuf[lo];
				if (cnt_wr[lo] || (step && at_end)) begin
					n16 = '0; // R11
				end else if (step) begin
					n16 = c16 + 16'h0001;
				end else begin
					n16 = c16;
				end
				next_cnt[hi]  = n16[15:8];
				next_cnt[lo]  = n16[7:0];
				next_wave[hi] = wave[hi];
				next_wave[lo] = (!run[lo] || (step && at_end)) ? pol : wave[lo];
				if (step && n16 == {next_dbuf[hi], next_dbuf[lo]}) begin
					next_wave[lo] = ~pol; // R8
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				cnt[i]  <= RST_CTRL;
				pbuf[i] <= RST_PER;
				dbuf[i] <= RST_DTY;
			end
			wave <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				cnt[i]  <= next_cnt[i];
				pbuf[i] <= next_pbuf[i];
				dbuf[i] <= next_dbuf[i];
			end
			wave <= next_wave;
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clk_sel <= RST_CTRL;
			pol_src <= RST_CTRL;
			scale   <= RST_CTRL;
			enable  <= RST_CTRL;
			for (int i = 0; i < NUM_CH; i++) begin
				per[i] <= RST_PER; // R23
				dty[i] <= RST_DTY; // R23
			end
		end else if (wr) begin
			if (addr == OFF_CLK_SEL) begin
				clk_sel <= wdata & CLK_SEL_MASK; // R17
			end
			if (addr == OFF_POL_SRC) begin
				pol_src <= wdata;
			end
			if (addr == OFF_SCALE) begin
				scale <= wdata;
			end
			if (addr == OFF_ENABLE) begin
				enable <= wdata & ENABLE_MASK;
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr == OFF_PER + 8'(i)) begin
					per[i] <= wdata;
				end
				if (addr == OFF_DTY + 8'(i)) begin
					dty[i] <= wdata;
				end
			end
		end
	end

	// ==========================================================
	// Register reads
	// Period and duty read back the last written value, not the buffer
	function automatic logic [7:0] reg_val(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == OFF_CLK_SEL) begin
			v = clk_sel;
		end else if (a == OFF_POL_SRC) begin
			v = pol_src;
		end else if (a == OFF_SCALE) begin
			v = scale;
		end else if (a == OFF_ENABLE) begin
			v = enable;
		end else if (a[7:2] == OFF_CNT[7:2]) begin
			v = cnt[a[1:0]];
		end else if (a[7:2] == OFF_PER[7:2]) begin
			v = per[a[1:0]];
		end else if (a[7:2] == OFF_DTY[7:2]) begin
			v = dty[a[1:0]];
		end
		return v;
	endfunction

	// High bytes sit on even channel indices of the counter, period, duty rows
	assign hi_read = rd && addr[7:4] == OFF_CNT[7:4] && addr[3:2] != 2'b00 && !addr[0]
		&& chain[addr[1]];

	always_comb begin
		next_rdata = 8'h00;
		if (rd) begin
			next_rdata = reg_val(addr);
			if (lat_vld && addr == lat_addr) begin
				next_rdata = lat_val; // R10
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lat_vld  <= 1'b0;
			lat_addr <= 8'h00;
			lat_val  <= 8'h00;
			rdata    <= 8'h00;
		end else begin
			lat_vld <= hi_read; // R10
			if (hi_read) begin
				lat_addr <= addr + 8'h01;
				lat_val  <= reg_val(addr + 8'h01); // R10
			end
			rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Port lines
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wave_out <= '0;
			pin_oe_n <= 4'hF;
		end else begin
			wave_out <= wave; // R1
			for (int i = 0; i < NUM_CH; i++) begin
				pin_oe_n[i] <= !(enable[EN_LSB+i] && !(chain[i/2] && (i % 2 == 0))); // R9
			end
		end
	end

	// ==========================================================
	// Checks
	a_bit3_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // R17
		rd && addr == OFF_CLK_SEL |=> rdata[3] == 1'b0)
		else $error("clock select bit 3 read as one");

	a_cnt_write_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // R21
		cnt_wr[3] && !chain[1] |=> cnt[3] == 8'h00 && pbuf[3] == $past(per[3]))
		else $error("counter write did not clear and reload");

	a_pair_low_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
		cnt_wr[1] && chain[0] |=> cnt[0] == 8'h00 && cnt[1] == 8'h00)
		else $error("chained low write did not clear pair");

	a_hi_release: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
		chain[1] |=> pin_oe_n[2])
		else $error("chained high line still driven");

	a_enable_drive: assert property (@(posedge ref_clk) disable iff (!nrst) // R20
		enable[3] && !chain[1] |=> !pin_oe_n[3])
		else $error("enabled line not driven");

	a_period_end: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
		run[3] && tick[3] && !chain[1] && cnt[3] == pbuf[3] |=> cnt[3] == 8'h00)
		else $error("period match did not restart counter");

	a_start_level: assert property (@(posedge ref_clk) disable iff (!nrst) // R18
		run[3] && tick[3] && !chain[1] && cnt[3] == pbuf[3] && dty[3] != 8'h00
		|=> wave[3] == $past(pol_src[POL_LSB+3]))
		else $error("period start level wrong");

	a_scaler_match: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
		a_en && s_match |=> scnt == 8'h00 && s_ff != $past(s_ff))
		else $error("scaler match did not reset and toggle");

	a_latch_read: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
		rd && addr == OFF_CNT && chain[0] ##1 rd && addr == OFF_CNT + 8'h01
		|=> rdata == $past(cnt[1], 2))
		else $error("low byte not latched by high read");

	a_idle_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R23
		!run[3] && !cnt_wr[3] && !chain[1] |=> cnt[3] == $past(cnt[3]))
		else $error("disabled counter moved");

endmodule

/* File: tb/pwm_load.sv */
// External pulled-up loads on the four port lines
`timescale 1ns/100ps
module pwm_load (
	input  wire logic [3:0] wave_out,
	input  wire logic [3:0] pin_oe_n,
	output logic      [3:0] line
);
	// ==========================================================
	// Line levels
	// A released line shows the pull-up, never the last driven level
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			line[i] = pin_oe_n[i] ? 1'b1 : wave_out[i];
		end
	end
endmodule

/* File: tb/pwm_timer_clock_and_concat_bench.sv */
// Register and waveform bench for the four-channel timer
`timescale 1ns/100ps
module pwm_timer_clock_and_concat_bench;
	import pwm_pkg::*;
	logic       ref_clk;
	logic       nrst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [3:0] wave_out;
	logic [3:0] pin_oe_n;
	logic [3:0] line;
	int         fail_count;
	int         comparisons;
	logic [7:0] v;
	logic [7:0] w;
	logic [7:0] rises;
	logic [7:0] highs;
	logic [7:0] cfg [4][5];

	pwm_timer pwm_timer_i (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.addr     (addr),
		.wdata    (wdata),
		.wr       (wr),
		.rd       (rd),
		.rdata    (rdata),
		.wave_out (wave_out),
		.pin_oe_n (pin_oe_n)
	);

	pwm_load pwm_load_i (
		.wave_out (wave_out),
		.pin_oe_n (pin_oe_n),
		.line     (line)
	);

	// ==========================================================
	// Clock and tasks
	initial begin
		ref_clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Three reads with no gap; returns the first and third answers
	task automatic rd_three(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2,
		output logic [7:0] d0, output logic [7:0] d2);
		@(posedge ref_clk);
		addr <= a0;
		rd   <= 1'b1;
		@(posedge ref_clk);
		addr <= a1;
		#1;
		d0 = rdata;
		@(posedge ref_clk);
		addr <= a2;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d2 = rdata;
	endtask

	// Counts highs and rising edges on line 3; window is whole periods so phase is irrelevant
	task automatic measure(input int n);
		logic prev;
		@(negedge ref_clk);
		prev  = line[3];
		rises = 8'h00;
		highs = 8'h00;
		repeat (n) begin
			@(negedge ref_clk);
			if (line[3]) highs++;
			if (line[3] && !prev) rises++;
			prev = line[3];
		end
	endtask

	task automatic tally_and_finish;
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#(CLK_PERIOD_NS * 8000);
		fail_count++;
		tally_and_finish();
	end

	// ==========================================================
	// Tests
	initial begin
		nrst        = 1'b0;
		addr        = 8'h00;
		wdata       = 8'h00;
		wr          = 1'b0;
		rd          = 1'b0;
		fail_count  = 0;
		comparisons = 0;
		// Clock select, polarity/source, scale, expected rises, expected highs
		cfg = '{'{8'h00, 8'h08, 8'h00, 8'd16, 8'd16},
			'{8'h03, 8'h08, 8'h00, 8'd2, 8'd16},
			'{8'h00, 8'h00, 8'h00, 8'd16, 8'd32},
			'{8'h10, 8'h88, 8'h01, 8'd4, 8'd16}};
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		check("oe_reset", {4'h0, pin_oe_n}, 8'h0F);
		rd_reg(OFF_CLK_SEL, v);
		check("clk_sel_reset", v, 8'h00);
		rd_reg(OFF_ENABLE, v);
		check("enable_reset", v, 8'h00);
		rd_reg(OFF_PER + 8'h03, v);
		check("period_reset", v, RST_PER);
		rd_reg(OFF_CNT + 8'h03, v);
		check("count_reset", v, 8'h00);
		// Channel 4 on line 3, period 2, duty 1
		wr_reg(OFF_PER + 8'h03, 8'h02);
		wr_reg(OFF_DTY + 8'h03, 8'h01);
		wr_reg(OFF_ENABLE, 8'h08);
		wr_reg(OFF_CNT + 8'h03, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr_reg(OFF_CLK_SEL, cfg[r][0]);
			wr_reg(OFF_POL_SRC, cfg[r][1]);
			wr_reg(OFF_SCALE, cfg[r][2]);
			// A lowered scale value is only met after the scaler wraps, up to 512 cycles
			repeat (600) @(posedge ref_clk);
			measure(48);
			check("rises", rises, cfg[r][3]);
			check("highs", highs, cfg[r][4]);
		end
		check("oe_single", {4'h0, pin_oe_n}, 8'h07);
		// Chain 1-2: line 0 released, line 1 carries the pair
		wr_reg(OFF_CLK_SEL, 8'h40);
		wr_reg(OFF_ENABLE, 8'h0B);
		repeat (4) @(posedge ref_clk);
		check("oe_chain", {4'h0, pin_oe_n}, 8'h05);
		// Pair counts once per cycle on clock A undivided
		wr_reg(OFF_CNT + 8'h01, 8'h00);
		rd_reg(OFF_CNT + 8'h01, v);
		check("pair_clear", v, 8'h01);
		// Low byte after a high read is the one latched a cycle earlier
		rd_three(OFF_CNT + 8'h01, OFF_CNT, OFF_CNT + 8'h01, v, w);
		check("latch_low", w, v + 8'h01);
		// Counter write clears while disabled
		wr_reg(OFF_ENABLE, 8'h00);
		wr_reg(OFF_CNT + 8'h03, 8'h55);
		rd_reg(OFF_CNT + 8'h03, v);
		check("count_clear", v, 8'h00);
		// Unimplemented bits and unmapped space
		wr_reg(OFF_CLK_SEL, 8'hFF);
		rd_reg(OFF_CLK_SEL, v);
		check("clk_sel_bit3", v, CLK_SEL_MASK);
		rd_reg(8'h70, v);
		check("unmapped", v, 8'h00);
		tally_and_finish();
	end
endmodule
